// ---- verilog/sfp_pkg.sv ----
`default_nettype none
// ==========================================================================
// Shared constants of the flash program/erase link
// ==========================================================================
package sfp_pkg;
  // ========================================================================
  // Command opcodes
  // ========================================================================
  localparam logic [7:0] OP_PROG_ERASE   = 8'h82;  // Buffer load, erase, program
  localparam logic [7:0] OP_PROG_NOERASE = 8'h02;  // Buffer load, program received only
  localparam logic [7:0] OP_PAGE_ERASE   = 8'h81;  // Erase one page

  // ========================================================================
  // Page geometry
  // ========================================================================
  localparam int PAGE_BYTES_STD = 264;             // Standard page size
  localparam int PAGE_BYTES_BIN = 256;             // Binary page size
  localparam int PAGE_W         = 10;              // Page index width
  localparam int BYTE_W         = 9;               // Buffer index width
  localparam int DATA_W         = 8;               // Byte width
  localparam int ADDR_BYTES     = 3;               // Address bytes after opcode
  localparam int HDR_BYTES      = 1 + ADDR_BYTES;  // Opcode plus address
  localparam logic [BYTE_W-1:0] LAST_STD = 9'h107; // Last index, 264 mode
  localparam logic [BYTE_W-1:0] LAST_BIN = 9'h0FF; // Last index, 256 mode

  // ========================================================================
  // Array word: erase flag, page, byte, data
  // ========================================================================
  localparam int WORD_W = 1 + PAGE_W + BYTE_W + DATA_W;

  // ========================================================================
  // Timing, clock at 250 MHz
  // ========================================================================
  localparam int CLK_PERIOD_NS         = 4;
  localparam int PAGE_ERASE_TIME_NS    = 8000;     // Longest page erase
  localparam int BYTE_PROGRAM_TIME_NS  = 40;       // Per programmed byte
  localparam int PAGE_ERASE_CYC        = PAGE_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int BYTE_PROGRAM_CYC      = BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W                 = 16;
  localparam int SCK_HALF_CYC          = 4;        // Host link clock half period
  localparam int HOST_GAP_CYC          = 16;       // Wait after deselect
  localparam int FIFO_DEPTH            = 4;
  localparam logic [2:0] LINK_IDLE     = 3'h2;     // Idle sck low, cs_n high, si low
endpackage : sfp_pkg
`default_nettype wire

// ---- verilog/sfp_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Serial link between host controller and flash device
// ==========================================================================
interface sfp_link_if;
  logic sck;    // Link clock, made by the host
  logic cs_n;   // Chip select, active low
  logic si;     // Serial data towards the device
  logic ready;  // Device ready (high) or busy (low)

  modport host (output sck, output cs_n, output si, input ready);
  modport dev  (input sck, input cs_n, input si, output ready);
endinterface : sfp_link_if
`default_nettype wire

// ---- verilog/sfp_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Small flop FIFO with valid/ready on both sides
// ==========================================================================
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];   // Storage
  logic [PW-1:0]    wr_ptr_r;        // Write index
  logic [PW-1:0]    rd_ptr_r;        // Read index
  logic [PW:0]      cnt_r;           // Occupancy

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  // Storage write, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : sfp_fifo
`default_nettype wire

// ---- verilog/sfp_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - 82h takes three address bytes, two layouts
// - Data bytes fill buffer, wrapping at end
// - 82h: erase page, then program buffer
// - Failed location sets the erase/program error flag
// - 02h takes three address bytes, same layouts
// - 02h accepts one to page-size data bytes
// - Binary pages: page and byte form linear address
// - 02h programs only bytes actually received
// - Deselect mid-byte aborts, nothing programmed
// - 02h busy time scales with byte count
// - Host pre-erases targets before 02h; the testbench sends 02h to page 1023 with no erase first
// - 81h takes three address bytes, page only
// - 81h erases addressed page, busy meanwhile
// - 82h does load, erase, program in one
// ==========================================================================
// Device end: command decode, buffer, self-timed sequencer
// ==========================================================================
module sfp_dev
  import sfp_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               nrst,
  // Serial link
  sfp_link_if.dev                 link,
  // Configuration
  input  wire logic               page_256,
  // Array write port
  output logic                    arr_valid,
  input  wire logic               arr_ready,
  output logic                    arr_erase,
  output logic [PAGE_W-1:0]       arr_page,
  output logic [BYTE_W-1:0]       arr_byte,
  output logic [DATA_W-1:0]       arr_data,
  input  wire logic               arr_fail,
  // Status
  output logic                    busy,
  output logic                    erase_program_error_flag
);
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,   // Taking commands
    SEQ_ERASE = 2'b01,   // Page erase running
    SEQ_PROG  = 2'b10,   // Walking buffer
    SEQ_DRAIN = 2'b11    // Waiting for array to take all
  } sfp_seq_type;

  // ========================================================================
  // Link input synchronisers: sck, cs_n, si
  // ========================================================================
  wire  [2:0] pin_raw = {link.sck, link.cs_n, link.si};
  logic [2:0] s1_r;        // First stage, only feeds s2
  logic [2:0] s2_r;        // Second stage
  logic [2:0] s3_r;        // Third stage
  logic [2:0] filt_r;      // Accepted level
  logic [2:0] filt_d_r;    // Accepted level, one cycle late

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // Change counts once stages two and three agree
      always_ff @(posedge clock) begin
        if (!nrst) begin
          // Idle levels, so leaving reset makes no false edge
          s1_r[gi]     <= LINK_IDLE[gi];
          s2_r[gi]     <= LINK_IDLE[gi];
          s3_r[gi]     <= LINK_IDLE[gi];
          filt_r[gi]   <= LINK_IDLE[gi];
          filt_d_r[gi] <= LINK_IDLE[gi];
        end else begin
          s1_r[gi]     <= pin_raw[gi];
          s2_r[gi]     <= s1_r[gi];
          s3_r[gi]     <= s2_r[gi];
          filt_r[gi]   <= (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
          filt_d_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  wire sel      = !filt_r[1];
  wire sck_rise = filt_r[2] && !filt_d_r[2];
  wire cs_fall  = !filt_r[1] && filt_d_r[1];
  wire cs_rise  = filt_r[1] && !filt_d_r[1];
  wire si_lvl   = filt_r[0];

  // ========================================================================
  // Receive state
  // ========================================================================
  sfp_seq_type         state_r;                    // Sequencer state
  logic [2:0]          bit_cnt_r;                  // Bits of current byte
  logic [2:0]          hdr_cnt_r;                  // Header bytes seen
  logic [6:0]          shift_r;                    // Partial byte
  logic [7:0]          op_r;                       // Latched opcode
  logic [23:0]         addr_r;                     // Latched address bytes
  logic [BYTE_W-1:0]   wr_idx_r;                   // Buffer fill index
  logic [DATA_W-1:0]   buf_r [PAGE_BYTES_STD];     // Page buffer
  logic [PAGE_BYTES_STD-1:0] got_r;                // Positions received
  logic                mode256_r;                  // Page size of this command

  wire [7:0]        byte_now  = {shift_r, si_lvl};
  wire              byte_done = sel && sck_rise && (bit_cnt_r == 3'h7) && (state_r == SEQ_IDLE);
  wire              hdr_full  = (hdr_cnt_r == 3'(HDR_BYTES));
  wire [BYTE_W-1:0] last_idx  = mode256_r ? LAST_BIN : LAST_STD;

  // Address layouts: 5/10/9 standard, 6/10/8 binary
  // Binary mode: bits 17..0 are page above byte, one linear location
  wire [PAGE_W-1:0] page_index_field  = mode256_r ? addr_r[17:8] : addr_r[18:9];
  // Start position, formed as the last address byte completes
  wire [BYTE_W-1:0] buffer_byte_index = mode256_r ? {1'b0, byte_now} : {addr_r[0], byte_now};
  wire [BYTE_W-1:0] fill_idx  = (hdr_cnt_r == 3'(HDR_BYTES - 1)) ? buffer_byte_index : wr_idx_r;
  wire [BYTE_W-1:0] next_idx  = (wr_idx_r >= last_idx) ? '0 : wr_idx_r + 1'b1;
  wire is_prog   = (op_r == OP_PROG_ERASE) || (op_r == OP_PROG_NOERASE);
  wire is_known  = is_prog || (op_r == OP_PAGE_ERASE);
  // Whole bytes only, header complete, known opcode
  wire start_ok  = cs_rise && (state_r == SEQ_IDLE) && (bit_cnt_r == 3'h0) && hdr_full && is_known;

  // Bit and byte counting on link clock rises
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bit_cnt_r <= 3'h0;
      hdr_cnt_r <= 3'h0;
      shift_r   <= 7'h00;
      op_r      <= 8'h00;
      addr_r    <= 24'h000000;
      mode256_r <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_r <= 3'h0;
      hdr_cnt_r <= 3'h0;
      mode256_r <= page_256;
    end else if (sel && sck_rise && state_r == SEQ_IDLE) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      shift_r   <= byte_now[6:0];
      if (byte_done && !hdr_full) begin
        hdr_cnt_r <= hdr_cnt_r + 1'b1;
        if (hdr_cnt_r == 3'h0) begin
          op_r <= byte_now;
        end else begin
          addr_r <= {addr_r[15:0], byte_now};
        end
      end
    end
  end

  // Buffer fill with wrap after last location
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_idx_r <= '0;
      got_r    <= '0;
    end else if (cs_fall && state_r == SEQ_IDLE) begin
      got_r <= '0;                                 // New command, no bytes yet
    end else if (byte_done && is_prog && hdr_cnt_r >= 3'(HDR_BYTES - 1)) begin
      if (hdr_full) begin
        buf_r[wr_idx_r] <= byte_now;
        got_r[wr_idx_r] <= 1'b1;
        wr_idx_r        <= next_idx;
      end else begin
        wr_idx_r <= (fill_idx > last_idx) ? '0 : fill_idx;  // Start position
      end
    end
  end

  // ========================================================================
  // Self-timed sequencer
  // ========================================================================
  logic [TMR_W-1:0]  tmr_r;       // Wait count
  logic [BYTE_W-1:0] scan_r;      // Program walk index
  logic              push_r;      // Word offered to FIFO
  logic [WORD_W-1:0] word_r;      // Offered word
  logic              err_r;       // Error flag
  logic              ready_r;     // Link ready output
  logic              busy_r;      // Status busy output
  logic              f_in_ready;
  logic              f_out_valid;
  logic [WORD_W-1:0] f_out_data;
  logic              av_r;
  logic [WORD_W-1:0] aw_r;

  wire pushed   = push_r && f_in_ready;
  wire scan_end = (scan_r == last_idx);
  // 82h programs whole buffer, 02h only received places
  wire take_pos = (op_r == OP_PROG_ERASE) || got_r[scan_r];

  // Sequencer steps
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= SEQ_IDLE;
      tmr_r   <= '0;
      scan_r  <= '0;
      push_r  <= 1'b0;
      word_r  <= '0;
    end else begin
      unique case (state_r)
        SEQ_IDLE: begin
          if (start_ok) begin
            if (op_r == OP_PROG_NOERASE) begin
              state_r <= SEQ_PROG;               // No erase first
              scan_r  <= '0;
            end else begin
              // Erase word, array sets page to all ones
              state_r <= SEQ_ERASE;
              push_r  <= 1'b1;
              word_r  <= {1'b1, page_index_field, {BYTE_W{1'b0}}, 8'hFF};
              tmr_r   <= TMR_W'(PAGE_ERASE_CYC);
            end
          end
        end
        SEQ_ERASE: begin
          if (pushed) begin
            push_r <= 1'b0;
          end
          if (!push_r && tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
          end else if (!push_r) begin
            // 81h ends here, 82h goes on to program
            state_r <= (op_r == OP_PAGE_ERASE) ? SEQ_DRAIN : SEQ_PROG;
            scan_r  <= '0;
          end
        end
        SEQ_PROG: begin
          if (pushed) begin
            push_r <= 1'b0;
          end else if (push_r) begin
            push_r <= 1'b1;                      // Stalled by full FIFO
          end else if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;               // Per-byte time
          end else if (take_pos && !(scan_r == '1)) begin
            push_r <= 1'b1;
            word_r <= {1'b0, page_index_field, scan_r, buf_r[scan_r]};
            tmr_r  <= TMR_W'(BYTE_PROGRAM_CYC);
            scan_r <= scan_end ? '1 : scan_r + 1'b1;
          end else if (scan_end || scan_r == '1) begin
            state_r <= SEQ_DRAIN;
          end else begin
            scan_r <= scan_r + 1'b1;
          end
        end
        SEQ_DRAIN: begin
          if (!f_out_valid && !av_r) begin
            state_r <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Error flag: fail report sets, new operation clears, set wins
  always_ff @(posedge clock) begin
    if (!nrst) begin
      err_r <= 1'b0;
    end else if (arr_fail) begin
      err_r <= 1'b1;
    end else if (start_ok) begin
      err_r <= 1'b0;
    end
  end

  // Busy from start until array has taken every word
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_r  <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      busy_r  <= start_ok || (state_r != SEQ_IDLE && !(state_r == SEQ_DRAIN && !f_out_valid && !av_r));
      ready_r <= !(start_ok || (state_r != SEQ_IDLE && !(state_r == SEQ_DRAIN && !f_out_valid && !av_r)));
    end
  end

  // ========================================================================
  // Array word path: FIFO then output register
  // ========================================================================
  sfp_fifo #(.WIDTH(WORD_W), .DEPTH(FDEPTH)) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (push_r),
    .in_ready  (f_in_ready),
    .in_data   (word_r),
    .out_valid (f_out_valid),
    .out_ready (!av_r || arr_ready),
    .out_data  (f_out_data)
  );

  // Output stage, refilled when empty or taken
  always_ff @(posedge clock) begin
    if (!nrst) begin
      av_r <= 1'b0;
      aw_r <= '0;
    end else if (!av_r || arr_ready) begin
      av_r <= f_out_valid;
      aw_r <= f_out_data;
    end
  end

  assign arr_valid                = av_r;
  assign {arr_erase, arr_page, arr_byte, arr_data} = aw_r;
  assign busy                     = busy_r;
  assign erase_program_error_flag = err_r;
  assign link.ready               = ready_r;
endmodule : sfp_dev
`default_nettype wire

// ---- verilog/sfp_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Host end: shifts one command out per request
// ==========================================================================
module sfp_host
  import sfp_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYC
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // Serial link
  sfp_link_if.host               link,
  // Command request
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic [7:0]        cmd_opcode,
  input  wire logic [PAGE_W-1:0] cmd_page,
  input  wire logic [BYTE_W-1:0] cmd_byte,
  input  wire logic [BYTE_W-1:0] cmd_count,
  input  wire logic              page_256,
  // Data bytes
  input  wire logic              data_valid,
  output logic                   data_ready,
  input  wire logic [7:0]        data_in,
  // Status
  output logic                   dev_busy
);
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,  // Waiting for command and ready device
    H_LOAD  = 2'b01,  // Fetch next byte
    H_SHIFT = 2'b10,  // Clock eight bits out
    H_END   = 2'b11   // Deselect and gap
  } sfp_host_type;

  sfp_host_type     st_r;
  logic [7:0]       div_r;       // Half-period divider
  logic             sck_r, cs_n_r, si_r, crdy_r, drdy_r, busy_r;
  logic [7:0]       sh_r;        // Outgoing byte
  logic [2:0]       bit_r;       // Bits sent of byte
  logic [BYTE_W:0]  left_r;      // Bytes still to send
  logic [2:0]       hdr_r;       // Header bytes sent
  logic [31:0]      hdr_word_r;  // Opcode and address
  logic [7:0]       gap_r;       // Deselect gap
  logic             r1_r, r2_r, r3_r, rdy_r;

  wire tick = (div_r == 8'(HALF - 1));
  wire take = cmd_valid && crdy_r;

  // Ready line synchroniser, counted when stages agree
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Ready idles high; no false busy after reset
      r1_r  <= 1'b1;
      r2_r  <= 1'b1;
      r3_r  <= 1'b1;
      rdy_r <= 1'b1;
    end else begin
      r1_r  <= link.ready;
      r2_r  <= r1_r;
      r3_r  <= r2_r;
      rdy_r <= (r2_r == r3_r) ? r3_r : rdy_r;
    end
  end

  // Link clock divider, enable pulse each half period
  always_ff @(posedge clock) begin
    if (!nrst || st_r == H_IDLE) begin
      div_r <= 8'h00;
    end else begin
      div_r <= tick ? 8'h00 : div_r + 1'b1;
    end
  end

  // Command sequencer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r <= H_IDLE; sck_r <= 1'b0; cs_n_r <= 1'b1; si_r <= 1'b0;
      crdy_r <= 1'b0; drdy_r <= 1'b0; busy_r <= 1'b0; sh_r <= 8'h00;
      bit_r <= 3'h0; left_r <= '0; hdr_r <= 3'h0; hdr_word_r <= '0; gap_r <= 8'h00;
    end else begin
      busy_r <= !rdy_r;
      unique case (st_r)
        H_IDLE: begin
          crdy_r <= rdy_r && !take;
          if (take) begin
            st_r   <= H_LOAD;
            cs_n_r <= 1'b0;
            hdr_r  <= 3'h0;
            // Layouts for 82h, 02h, 81h
            hdr_word_r <= page_256 ? {cmd_opcode, 6'h00, cmd_page, cmd_byte[7:0]}
                                   : {cmd_opcode, 5'h00, cmd_page, cmd_byte};
            // 81h sends no data; programs send one to page size
            left_r <= (cmd_opcode == OP_PAGE_ERASE) ? (BYTE_W+1)'(HDR_BYTES)
                                                    : (BYTE_W+1)'(HDR_BYTES) + {1'b0, cmd_count};
          end
        end
        H_LOAD: begin
          if (hdr_r != 3'(HDR_BYTES)) begin
            sh_r <= hdr_word_r[31:24]; si_r <= hdr_word_r[31];
            hdr_word_r <= {hdr_word_r[23:0], 8'h00};
            hdr_r <= hdr_r + 1'b1; bit_r <= 3'h0; st_r <= H_SHIFT;
          end else if (drdy_r && data_valid) begin
            drdy_r <= 1'b0;
            sh_r <= data_in; si_r <= data_in[7]; bit_r <= 3'h0; st_r <= H_SHIFT;
          end else begin
            drdy_r <= 1'b1;                     // Wait for user byte
          end
        end
        H_SHIFT: begin
          if (tick && !sck_r) begin
            sck_r <= 1'b1;                      // Device samples on rise
          end else if (tick) begin
            sck_r <= 1'b0;
            sh_r  <= {sh_r[6:0], 1'b0};
            si_r  <= sh_r[6];
            bit_r <= bit_r + 1'b1;
            if (bit_r == 3'h7) begin
              left_r <= left_r - 1'b1;
              // Deselect only on a byte boundary
              st_r  <= (left_r == (BYTE_W+1)'(1)) ? H_END : H_LOAD;
              gap_r <= 8'h00;
            end
          end
        end
        H_END: begin
          if (tick) begin
            cs_n_r <= 1'b1;
          end
          if (cs_n_r) begin
            gap_r <= gap_r + 1'b1;
            // Hold off until device busy is visible
            if (gap_r == 8'(HOST_GAP_CYC)) begin
              st_r <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign link.sck   = sck_r;
  assign link.cs_n  = cs_n_r;
  assign link.si    = si_r;
  assign cmd_ready  = crdy_r;
  assign data_ready = drdy_r;
  assign dev_busy   = busy_r;
endmodule : sfp_host
`default_nettype wire

// ---- verif/sfp_link_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Link checks between host and device ends
// ==========================================================================
module sfp_link_assertions (
  // Clock, reset and link lines
  input wire logic clock,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic ready
);
  logic [2:0] bits_r;  // Bits of the current byte
  // Count link clock rises while selected
  always_ff @(posedge clock) begin
    if (!nrst || cs_n) bits_r <= 3'h0;
    else if ($rose(sck)) bits_r <= bits_r + 3'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("link clock moved while idle");
  property p_si_hold; sck && $past(sck) |-> $stable(si); endproperty
  a_si_hold: assert property (p_si_hold) else $error("data moved while clock high");
  property p_sck_half; $rose(sck) |-> sck [*3]; endproperty
  a_sck_half: assert property (p_sck_half) else $error("link clock high too short");
  property p_byte_end; $rose(cs_n) |-> bits_r == 3'h0; endproperty
  a_byte_end: assert property (p_byte_end) else $error("deselect inside a byte");
  property p_start_desel; $fell(ready) |-> cs_n && $past(cs_n); endproperty
  a_start_desel: assert property (p_start_desel) else $error("busy before deselect");
  property p_busy_min; $fell(ready) |-> !ready [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_sel_ready; $fell(cs_n) |-> ready; endproperty
  a_sel_ready: assert property (p_sel_ready) else $error("select while busy");
  property p_busy_desel; !ready |-> cs_n; endproperty
  a_busy_desel: assert property (p_busy_desel) else $error("selected during busy");
endmodule // sfp_link_assertions
`default_nettype wire

// ---- verif/serial_flash_program_erase_cmds_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Host and device back to back, array port modelled here
// ==========================================================================
module serial_flash_program_erase_cmds_tb;
  import sfp_pkg::*;
  logic clock = 0, nrst = 0, cmd_valid = 0, data_valid = 0, arr_ready = 0, arr_fail = 0, p256 = 0;
  logic [7:0] cmd_opcode = 0, data_in = 0, dbuf[264];
  logic [PAGE_W-1:0] cmd_page = 0, arr_page;
  logic [BYTE_W-1:0] cmd_byte = 0, cmd_count = 0, arr_byte;
  logic [7:0] arr_data;
  logic cmd_ready, data_ready, arr_valid, arr_erase, busy, flag, hbusy, fe = 0;
  logic [WORD_W-1:0] exp_q[$];  // Expected array words
  int num_errors = 0, n_checks = 0, cyc = 0, di = 0, dn = 0, fail_req = 0, bufm[264];
  always #2 clock = ~clock;
  sfp_link_if link ();
  sfp_host i_sfp_host (.clock, .nrst, .link(link.host), .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_page,
    .cmd_byte, .cmd_count, .page_256(p256), .data_valid, .data_ready, .data_in, .dev_busy(hbusy));
  sfp_dev i_sfp_dev (.clock, .nrst, .link(link.dev), .page_256(p256), .arr_valid, .arr_ready, .arr_erase,
    .arr_page, .arr_byte, .arr_data, .arr_fail, .busy, .erase_program_error_flag(flag));
  sfp_link_assertions i_chk (.clock, .nrst, .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .ready(link.ready));
  task chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] want, input string m);
    n_checks++;
    if (got !== want) begin num_errors++; $display("CHECK FAILED %0t %s", $time, m); end
  endtask
  task close_out();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ========================================================================
  // Data feeder, array with random stalls, hang guard
  // ========================================================================
  always @(posedge clock) begin
    cyc++;
    if (cyc > 90000) begin num_errors++; close_out(); end
    if (data_valid && data_ready) di++;
    data_valid <= di < dn;
    data_in <= dbuf[di % 264];
    if (arr_valid && arr_ready)
      chk({arr_erase, arr_page, arr_byte, arr_data}, exp_q.size() ? exp_q.pop_front() : 'x, "array word");
    arr_fail <= fail_req != 0 && arr_valid && arr_ready;
    arr_ready <= ($urandom % 4) != 0;
  end
  // One command: model, drive, wait for idle, compare
  task run(input logic [7:0] op, input int pg, input int st, input int cnt, input logic pm, input int fl);
    int last, b;
    bit got[264];
    last = pm ? 255 : 263;
    for (b = 0; b < 264; b++) got[b] = 0;
    for (b = 0; b < cnt; b++) dbuf[b] = 8'($urandom);
    if (op == OP_PROG_ERASE || op == OP_PROG_NOERASE)
      for (b = 0; b < cnt; b++) begin bufm[(st + b) % (last + 1)] = dbuf[b]; got[(st + b) % (last + 1)] = 1; end
    if (op == OP_PAGE_ERASE || op == OP_PROG_ERASE) exp_q.push_back({1'b1, pg[9:0], 9'h0, 8'hFF});
    if (op == OP_PROG_ERASE || op == OP_PROG_NOERASE)
      for (b = 0; b <= last; b++)
        if (op == OP_PROG_ERASE || got[b]) exp_q.push_back({1'b0, pg[9:0], b[8:0], 8'(bufm[b])});
    if (fl != 0) fe = 1;
    else if (op == OP_PAGE_ERASE || op == OP_PROG_ERASE || op == OP_PROG_NOERASE) fe = 0;
    fail_req = fl;
    dn = (op == OP_PAGE_ERASE) ? 0 : cnt;
    di = 0;
    @(posedge clock);
    cmd_valid <= 1; cmd_opcode <= op; cmd_page <= pg[9:0]; cmd_byte <= st[8:0]; cmd_count <= cnt[8:0]; p256 <= pm;
    b = 0;
    do begin @(posedge clock); b++; end while (cmd_ready !== 1'b1 && b < 20000);
    cmd_valid <= 0;
    chk(hbusy, 0, "host busy at take");
    b = 0;
    do begin @(posedge clock); b++; end
      while ((exp_q.size() != 0 || link.ready !== 1'b1 || link.cs_n !== 1'b1 || di < dn) && b < 30000);
    chk(exp_q.size(), 0, "words missing");
    chk(busy, 0, "still busy");
    chk(flag, fe, "error flag");
    fail_req = 0;
  endtask
  initial begin
    void'($urandom(32'h42834EA4));
    repeat (2) @(posedge clock);
    nrst <= 1;
    run(OP_PROG_ERASE, 5, 262, 264, 0, 0);
    run(OP_PROG_NOERASE, 1023, 254, 3, 1, 0);
    run(OP_PAGE_ERASE, $urandom % 1024, 0, 0, 0, 1);
    run(8'h84, 7, 0, 2, 0, 0);
    run(OP_PROG_NOERASE, $urandom % 1024, $urandom % 264, 1, 0, 0);
    run(OP_PROG_ERASE, $urandom % 1024, $urandom % 256, 1 + $urandom % 8, 1, 0);
    close_out();
  end
endmodule // serial_flash_program_erase_cmds_tb
`default_nettype wire
